// >>> rtl/ltr_map.vh
// ltr_map.vh: register offsets, field positions and reset values
// assumes 32-bit apb data, one register per aligned word
`ifndef LTR_MAP_VH
`define LTR_MAP_VH

// register byte offsets
`define LTR_OFS_CTRL     8'h00
`define LTR_OFS_FUNC_A   8'h04
`define LTR_OFS_FUNC_B   8'h08
`define LTR_OFS_FILTER   8'h0C
`define LTR_OFS_THRESHOLD_MONITOR   8'h10
`define LTR_OFS_STATUS   8'h14
`define LTR_OFS_DISARM   8'h18

// control register fields
`define LTR_CTRL_SEL_B     0
`define LTR_CTRL_SEQ       1
`define LTR_CTRL_EXT_EN    2
`define LTR_CTRL_EXT_FALL  3
`define LTR_CTRL_VIEW_CLK  4
`define LTR_CTRL_FILT_EN   5
`define LTR_CTRL_ECL       6
`define LTR_CTRL_PROG      7
`define LTR_CTRL_MON       8
`define LTR_CTRL_CHAN_LO   9
`define LTR_CTRL_CHAN_HI   10
`define LTR_CTRL_WIDTH     11

// product term layout inside a half word of a function register
`define LTR_P_USE_LO   0
`define LTR_P_USE_HI   3
`define LTR_P_NEG_LO   4
`define LTR_P_NEG_HI   7
`define LTR_P_EDGE     8
`define LTR_P_ECH_LO   9
`define LTR_P_ECH_HI   10
`define LTR_P_WIDTH    11
`define LTR_P2_LO      16

// reset values; threshold codes are on the sample scale of the channel inputs
`define LTR_RST_CTRL   11'h000
`define LTR_RST_FUNC   32'h0000_0000
`define LTR_RST_FILT   16'h0000
`define LTR_PRE_TTL    8'h8C
`define LTR_PRE_ECL    8'h2D

`endif

// >>> rtl/ltr_top.v
// ltr_top: four-channel logic trigger recogniser with apb register access
// assumes channel samples and the qualifying clock are synchronous to CLK_SYS
//
// Summary of operation
// - two trigger functions A and B are stored; the selected one is evaluated
// - trigger is high while the selected function is true, low otherwise
// - products AND chosen channels, plain or negated; products are ORed
// - trigger goes to time base and trigger out; not out in ext sync
// - trigger view follows trigger state, aligned with channel sampling
// - external clock edge, rising or falling, qualifies the function; may be viewed
// - each channel compared with its own threshold
// - preset ttl/ecl threshold; adjust only in program mode with monitor on
// - filter drops function-true intervals shorter than a set minimum
// - one edge channel per product, two products per function
// - sequential mode: A arms, next B produces the trigger
// - filter bypassed for functions holding an edge channel
//
// Our own choices: the APB register port and the address map.
`include "ltr_map.vh"

module ltr_top (
  input  wire        CLK_SYS,
  input  wire        RSTN,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  input  wire [7:0]  INPUT_CHANNEL_ONE,
  input  wire [7:0]  INPUT_CHANNEL_TWO,
  input  wire [7:0]  INPUT_CHANNEL_THREE,
  input  wire [7:0]  INPUT_CHANNEL_FOUR,
  input  wire        QUALIFYING_CLOCK_IN,
  output reg         TRIG_TIMEBASE,
  output reg         TRIG_OUT,
  output reg         TRIGGER_VIEW_TRACE
);

  //////////////////////////////////////////////////////////////////////////////
  // product evaluation: level terms and an optional edge term

  // empty product (no channel, no edge) never matches
  function prod_eval;
    input [10:0] p;
    input [3:0]  lv;
    input [3:0]  rs;
    input [3:0]  fl;
    reg   [3:0]  m;
    reg   [1:0]  ec;
    reg          ev;
    begin
      m  = p[`LTR_P_USE_HI:`LTR_P_USE_LO];
      ec = p[`LTR_P_ECH_HI:`LTR_P_ECH_LO];
      ev = 1'b1;
      if (p[`LTR_P_EDGE]) begin
        m[ec] = 1'b0;                                  // edge channel leaves level terms
        ev    = p[`LTR_P_NEG_LO + ec] ? fl[ec] : rs[ec]; // negate selects falling edge
      end
      prod_eval = (&((lv ^ p[`LTR_P_NEG_HI:`LTR_P_NEG_LO]) | ~m)) & ev &
                  (|p[`LTR_P_USE_HI:`LTR_P_USE_LO] | p[`LTR_P_EDGE]);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // registers

  reg  [10:0] ctrl_r;
  reg  [31:0] func_a_r;
  reg  [31:0] func_b_r;
  reg  [15:0] filt_lim_r;
  reg  [7:0]  thr_r [0:3];
  reg  [3:0]  lvl_prev_r;
  reg         qclk_prev_r;
  reg         armed_r;
  reg  [15:0] cnt_a_r;
  reg  [15:0] cnt_b_r;

  wire        wr_en  = PSEL & PENABLE & PWRITE;
  wire        mapped = (PADDR <= `LTR_OFS_DISARM) && (PADDR[1:0] == 2'b00);
  wire [1:0]  sel_ch = ctrl_r[`LTR_CTRL_CHAN_HI:`LTR_CTRL_CHAN_LO];
  wire [7:0]  preset = ctrl_r[`LTR_CTRL_ECL] ? `LTR_PRE_ECL : `LTR_PRE_TTL;

  // zero-wait slave; unmapped or misaligned addresses answer with an error
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  //////////////////////////////////////////////////////////////////////////////
  // channel classification and edge detection

  wire [3:0] lvl;
  assign lvl[0] = INPUT_CHANNEL_ONE   >= thr_r[0];
  assign lvl[1] = INPUT_CHANNEL_TWO   >= thr_r[1];
  assign lvl[2] = INPUT_CHANNEL_THREE >= thr_r[2];
  assign lvl[3] = INPUT_CHANNEL_FOUR  >= thr_r[3];

  wire [3:0] rise = lvl & ~lvl_prev_r;
  wire [3:0] fall = ~lvl & lvl_prev_r;

  // two products ORed per function
  wire raw_a = prod_eval(func_a_r[10:0], lvl, rise, fall) |
               prod_eval(func_a_r[`LTR_P2_LO+10:`LTR_P2_LO], lvl, rise, fall);
  wire raw_b = prod_eval(func_b_r[10:0], lvl, rise, fall) |
               prod_eval(func_b_r[`LTR_P2_LO+10:`LTR_P2_LO], lvl, rise, fall);

  wire edge_a = func_a_r[`LTR_P_EDGE] | func_a_r[`LTR_P2_LO+`LTR_P_EDGE];
  wire edge_b = func_b_r[`LTR_P_EDGE] | func_b_r[`LTR_P2_LO+`LTR_P_EDGE];

  //////////////////////////////////////////////////////////////////////////////
  // minimum-duration filter, one counter per function

  // a limit of zero passes the function straight through
  wire filt_on = ctrl_r[`LTR_CTRL_FILT_EN];
  wire fa = raw_a & (~filt_on | edge_a | (cnt_a_r == filt_lim_r));
  wire fb = raw_b & (~filt_on | edge_b | (cnt_b_r == filt_lim_r));

  // counters restart whenever the function is false and saturate at the limit
  always @(posedge CLK_SYS) begin
    if (!RSTN) begin
      cnt_a_r <= 16'h0000;
      cnt_b_r <= 16'h0000;
    end else begin
      if (!raw_a)
        cnt_a_r <= 16'h0000;
      else if (cnt_a_r != filt_lim_r)
        cnt_a_r <= cnt_a_r + 16'h0001;
      if (!raw_b)
        cnt_b_r <= 16'h0000;
      else if (cnt_b_r != filt_lim_r)
        cnt_b_r <= cnt_b_r + 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // function selection, sequencing and external clock qualification

  wire seq     = ctrl_r[`LTR_CTRL_SEQ];
  wire ext_en  = ctrl_r[`LTR_CTRL_EXT_EN];
  wire func    = seq ? (armed_r & fb) :
                 (ctrl_r[`LTR_CTRL_SEL_B] ? fb : fa);
  wire qedge   = ctrl_r[`LTR_CTRL_EXT_FALL] ? (qclk_prev_r & ~QUALIFYING_CLOCK_IN) :
                 (~qclk_prev_r & QUALIFYING_CLOCK_IN);
  // qualified trigger lasts one cycle per chosen clock transition
  wire trig    = ext_en ? (qedge & func) : func;
  wire disarm  = wr_en & mapped & (PADDR == `LTR_OFS_DISARM);

  // arm on A; firing on B or a software disarm drops it, a new A wins
  always @(posedge CLK_SYS) begin
    if (!RSTN)
      armed_r <= 1'b0;
    else if (seq & fa)
      armed_r <= 1'b1;
    else if (!seq | disarm | trig)
      armed_r <= 1'b0;
  end

  // outputs registered together so the view trace stays aligned with the trigger
  always @(posedge CLK_SYS) begin
    if (!RSTN) begin
      TRIG_TIMEBASE      <= 1'b0;
      TRIG_OUT           <= 1'b0;
      TRIGGER_VIEW_TRACE <= 1'b0;
      lvl_prev_r         <= 4'h0;
      qclk_prev_r        <= 1'b0;
    end else begin
      TRIG_TIMEBASE      <= trig;
      TRIG_OUT           <= trig & ~ext_en;
      TRIGGER_VIEW_TRACE <= ctrl_r[`LTR_CTRL_VIEW_CLK] ? QUALIFYING_CLOCK_IN
                                                      : trig;
      lvl_prev_r         <= lvl;
      qclk_prev_r        <= QUALIFYING_CLOCK_IN;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register writes and thresholds

  wire ctrl_wr = wr_en & mapped & (PADDR == `LTR_OFS_CTRL);
  wire fam_chg = ctrl_wr & (PWDATA[`LTR_CTRL_ECL] != ctrl_r[`LTR_CTRL_ECL]);
  wire thr_wr  = wr_en & mapped & (PADDR == `LTR_OFS_THRESHOLD_MONITOR) &
                 ctrl_r[`LTR_CTRL_PROG] & ctrl_r[`LTR_CTRL_MON];
  wire [7:0] new_pre = PWDATA[`LTR_CTRL_ECL] ? `LTR_PRE_ECL : `LTR_PRE_TTL;

  always @(posedge CLK_SYS) begin
    if (!RSTN) begin
      ctrl_r     <= `LTR_RST_CTRL;
      func_a_r   <= `LTR_RST_FUNC;
      func_b_r   <= `LTR_RST_FUNC;
      filt_lim_r <= `LTR_RST_FILT;
    end else if (wr_en & mapped) begin
      case (PADDR)
        `LTR_OFS_CTRL:   ctrl_r     <= PWDATA[`LTR_CTRL_WIDTH-1:0];
        `LTR_OFS_FUNC_A: func_a_r   <= PWDATA;
        `LTR_OFS_FUNC_B: func_b_r   <= PWDATA;
        `LTR_OFS_FILTER: filt_lim_r <= PWDATA[15:0];
        default:         ;
      endcase
    end
  end

  // family change reverts every channel to its new preset
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_thr
      always @(posedge CLK_SYS) begin
        if (!RSTN)
          thr_r[gi] <= `LTR_PRE_TTL;
        else if (fam_chg)
          thr_r[gi] <= new_pre;
        else if (thr_wr && (sel_ch == gi))
          thr_r[gi] <= PWDATA[7:0];
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup phase and held through access

  reg [31:0] rd_nxt;
  always @* begin
    case (PADDR)
      `LTR_OFS_CTRL:   rd_nxt = {21'h00_0000, ctrl_r};
      `LTR_OFS_FUNC_A: rd_nxt = func_a_r;
      `LTR_OFS_FUNC_B: rd_nxt = func_b_r;
      `LTR_OFS_FILTER: rd_nxt = {16'h0000, filt_lim_r};
      `LTR_OFS_THRESHOLD_MONITOR: rd_nxt = {16'h0000, preset, thr_r[sel_ch]};
      `LTR_OFS_STATUS: rd_nxt = {24'h00_0000, TRIG_TIMEBASE, armed_r, fb, fa, lvl};
      default:         rd_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge CLK_SYS) begin
    if (!RSTN)
      PRDATA <= 32'h0000_0000;
    else if (PSEL & ~PENABLE & ~PWRITE)
      PRDATA <= rd_nxt;
  end

endmodule

// >>> test/ltr_checker.sv
// ltr_checker: port-level assertions for ltr_top
// assumes bind onto ltr_top, one clock, synchronous active-low reset
module ltr_checker (
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        TRIG_TIMEBASE,
  input wire logic        TRIG_OUT,
  input wire logic        TRIGGER_VIEW_TRACE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////////////////////////////////////////
  // apb access phase, and access to an unmapped or misaligned word
  sequence s_acc; PSEL && PENABLE; endsequence
  sequence s_bad; s_acc ##0 (PADDR > 8'h18 || PADDR[1:0] != 2'b00); endsequence
  property p_rdy; s_acc |-> PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready in access phase");
  property p_errph; PSLVERR |-> PSEL && PENABLE; endproperty
  a_errph: assert property (p_errph) else $error("error outside access phase");
  property p_err; s_bad |-> PSLVERR; endproperty
  a_err: assert property (p_err) else $error("unmapped access not flagged");
  property p_rd0; s_bad ##0 !PWRITE |-> PRDATA == 32'h0000_0000; endproperty
  a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
  // read data only moves after a read setup cycle
  property p_hold; !(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_out; TRIG_OUT |-> TRIG_TIMEBASE; endproperty
  a_out: assert property (p_out) else $error("trigger out without trigger");
  property p_st; s_acc ##0 (!PWRITE && PADDR == 8'h14) |-> PRDATA[7] == $past(TRIG_TIMEBASE); endproperty
  a_st: assert property (p_st) else $error("status trigger bit wrong");
  property p_rst; $rose(RSTN) |-> !TRIG_TIMEBASE && !TRIG_OUT && !TRIGGER_VIEW_TRACE; endproperty
  a_rst: assert property (p_rst) else $error("trigger high out of reset");
endmodule
bind ltr_top ltr_checker ltr_checker_inst (
  .CLK_SYS(CLK_SYS), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TRIG_TIMEBASE(TRIG_TIMEBASE), .TRIG_OUT(TRIG_OUT), .TRIGGER_VIEW_TRACE(TRIGGER_VIEW_TRACE)
);

// >>> test/ltr_probe_model.sv
// ltr_probe_model: probed circuit, turns logic levels into channel samples
// assumes the bench changes lvl and qclk right after a rising edge
module ltr_probe_model #(
  parameter logic [7:0] HI_CODE = 8'hA0,
  parameter logic [7:0] LO_CODE = 8'h10
) (
  input  wire logic [3:0] lvl,
  input  wire logic       qclk,
  output wire logic [7:0] ch_one,
  output wire logic [7:0] ch_two,
  output wire logic [7:0] ch_three,
  output wire logic [7:0] ch_four,
  output wire logic       qclk_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // high code sits above both presets, so only a raised threshold flips it
  assign ch_one   = lvl[0] ? HI_CODE : LO_CODE;
  assign ch_two   = lvl[1] ? HI_CODE : LO_CODE;
  assign ch_three = lvl[2] ? HI_CODE : LO_CODE;
  assign ch_four  = lvl[3] ? HI_CODE : LO_CODE;
  assign qclk_out = qclk;
endmodule

// >>> test/tb_ltr_top.sv
// tb_ltr_top: register and trigger tests for ltr_top
// assumes ltr_probe_model stands on the channel side
module tb_ltr_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rstn, psel, penable, pwrite, qclk;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rv, prdata;
  logic [3:0]  lv;
  logic [7:0]  c1, c2, c3, c4;
  logic        pready, pslverr, trig_tb, trig_out, view, qc, er;
  int          error_cnt, total_checks, x;
  ltr_probe_model ltr_probe_model_inst (.lvl(lv), .qclk(qclk), .ch_one(c1), .ch_two(c2),
    .ch_three(c3), .ch_four(c4), .qclk_out(qc));
  ltr_top ltr_top_inst (.CLK_SYS(clk_sys), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .INPUT_CHANNEL_ONE(c1), .INPUT_CHANNEL_TWO(c2),
    .INPUT_CHANNEL_THREE(c3), .INPUT_CHANNEL_FOUR(c4), .QUALIFYING_CLOCK_IN(qc),
    .TRIG_TIMEBASE(trig_tb), .TRIG_OUT(trig_out), .TRIGGER_VIEW_TRACE(view));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task end_sim;
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one apb transfer; the extra edge keeps back-to-back calls race free
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0000_0000);
    chk(rv, e);
  endtask
  // drive levels, check trigger, trigger out and view one cycle later
  task lvl(input logic [3:0] v, input logic [2:0] e);
    lv <= v;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk({trig_tb, trig_out, view}, e);
    @(posedge clk_sys);
  endtask
  // cycles until the trigger rises, bounded; trigger out level at that point
  task lat(input int e, input logic o);
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
      @(negedge clk_sys);
    end while (trig_tb !== 1'b1 && k < 20);
    chk(k, e);
    chk(trig_out, o);
    @(posedge clk_sys);
  endtask
  task quiet(input int m);
    repeat (m) begin
      @(negedge clk_sys);
      chk(trig_tb, 1'b0);
    end
    @(posedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    end_sim;
  end
  initial begin
    rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; lv = 0; qclk = 0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    for (x = 0; x < 16; x += 4) rdc(x[7:0], 32'h0000_0000);
    rdc(8'h10, 32'h0000_8C8C);
    chk(er, 1'b0);
    rdc(8'h1C, 32'h0000_0000);
    chk(er, 1'b1);
    // not one and two, or four; then function B alone, then A recalled
    acc(1'b1, 8'h04, 32'h0008_0013);
    for (x = 0; x < 16; x++) lvl(x[3:0], {3{x[1:0] == 2'b10 || x[3]}});
    acc(1'b1, 8'h08, 32'h0000_0004);
    acc(1'b1, 8'h00, 32'h0000_0001);
    for (x = 0; x < 16; x++) lvl(x[3:0], {3{x[2]}});
    acc(1'b1, 8'h00, 32'h0000_0000);
    lvl(4'b0010, 3'b111);
    // external clock, rising then falling qualifier
    acc(1'b1, 8'h04, 32'h0000_0001);
    lv <= 4'b0001;
    for (x = 0; x < 2; x++) begin
      acc(1'b1, 8'h00, x ? 32'h0000_000C : 32'h0000_0004);
      quiet(2);
      qclk <= !qclk;
      lat(1, 1'b0);
      quiet(2);
    end
    // thresholds: refused outside program mode, per channel, family reverts
    acc(1'b1, 8'h00, 32'h0000_0000);
    acc(1'b1, 8'h10, 32'h0000_00B0);
    rdc(8'h10, 32'h0000_8C8C);
    acc(1'b1, 8'h00, 32'h0000_0180);
    acc(1'b1, 8'h10, 32'h0000_00B0);
    rdc(8'h10, 32'h0000_8CB0);
    lv <= 4'hF;
    @(posedge clk_sys);
    acc(1'b0, 8'h14, 32'h0000_0000);
    chk(rv[3:0], 4'b1110);
    acc(1'b1, 8'h00, 32'h0000_01C0);
    rdc(8'h10, 32'h0000_2D2D);
    // filter of three cycles: short pulse dropped, long one delayed
    lv <= 4'h0;
    acc(1'b1, 8'h0C, 32'h0000_0003);
    acc(1'b1, 8'h00, 32'h0000_0020);
    lv <= 4'h1;
    repeat (3) @(posedge clk_sys);
    lv <= 4'h0;
    quiet(5);
    lv <= 4'h1;
    lat(4, 1'b1);
    // one edge per product: ch1 rising, ch2 falling, both unfiltered
    acc(1'b1, 8'h04, 32'h0320_0100);
    lv <= 4'b0010;
    quiet(3);
    lv <= 4'b0011;
    lat(1, 1'b1);
    lv <= 4'b0001;
    lat(1, 1'b1);
    // sequence A then B, and disarm
    lv <= 4'h0;
    acc(1'b1, 8'h04, 32'h0000_0001);
    acc(1'b1, 8'h08, 32'h0000_0002);
    acc(1'b1, 8'h00, 32'h0000_0002);
    acc(1'b1, 8'h18, 32'h0000_0000);
    lv <= 4'b0010;
    quiet(4);
    lv <= 4'b0001;
    @(posedge clk_sys);
    lv <= 4'b0000;
    repeat (2) @(posedge clk_sys);
    lv <= 4'b0010;
    lat(1, 1'b1);
    quiet(2);
    lv <= 4'b0001;
    @(posedge clk_sys);
    lv <= 4'b0000;
    acc(1'b1, 8'h18, 32'h0000_0000);
    lv <= 4'b0010;
    quiet(3);
    // channel four alone takes a raised threshold
    acc(1'b1, 8'h00, 32'h0000_0780);
    acc(1'b1, 8'h10, 32'h0000_00B0);
    rdc(8'h10, 32'h0000_8CB0);
    lv <= 4'hF;
    acc(1'b0, 8'h14, 32'h0000_0000);
    chk(rv[3:0], 4'b0111);
    // view trace shows the qualifying clock one cycle late, trigger unaffected
    acc(1'b1, 8'h00, 32'h0000_0010);
    qclk <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk({trig_tb, trig_out, view}, 3'b111);
    @(posedge clk_sys);
    qclk <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk({trig_tb, trig_out, view}, 3'b110);
    end_sim;
  end
endmodule
